/* hw/ring_descriptor_status_logic.sv */
// Descriptor rings with ownership handshake and status write-back
//
// Added by the designer: the APB register port and the register offsets.
`timescale 1ns/10ps
// Contract
// - Word 1 bit 15 is ownership; device clears it after filling rx buffer.
// - After handing an entry over, neither side writes any of its words.
// - Receive fault summary is OR of odd bits, overrun, CRC, chain miss.
// - Odd bits needs CRC error, last segment, no overrun, not loopback.
// - Receive overrun marks lost data; then last segment stays clear.
// - CRC error reported only with last segment set and no overrun.
// - Chain miss set when next rx entry is not owned while chaining.
// - With chain miss, overrun shown only when both occur together.
// - Device marks first and last rx segment; both means unchained.
// - Device writes byte count on last segment; host clears it.
// - Host sets tx ownership after filling; device clears after sending.
// - Transmit fault summary is OR of late, carrier, underrun, retry.
// - Append flag forces CRC despite suppress mode, only on first segment.
// - Multi retry for more than one retry, single for exactly one; code also needs no late collision for single.
// - Channel wait set when transmission had to defer on busy channel.
// - Owned tx entries without first segment are skipped while polling; code sends them while a packet is in progress.
// - Every entry is four consecutive 16-bit words.
module ring_descriptor_status_logic #(
   parameter int RING_DEPTH = 4
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [ring_desc_pkg::APB_ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic rx_seg_done,
   input wire logic rx_seg_last,
   input wire logic rx_odd_bits,
   input wire logic rx_crc_err,
   input wire logic rx_overflow,
   input wire logic [ring_desc_pkg::RX_COUNT_BITS-1:0] rx_byte_count,
   output logic rx_buf_ready,
   output logic [23:0] rx_buf_addr,
   input wire logic tx_seg_done,
   input wire logic tx_late_collision,
   input wire logic tx_carrier_lost,
   input wire logic tx_underrun,
   input wire logic tx_retry_exhausted,
   input wire logic tx_deferred,
   input wire logic [4:0] tx_retry_count,
   output logic tx_start,
   output logic tx_active,
   output logic [23:0] tx_buf_addr,
   output logic tx_buf_last,
   output logic tx_append_crc
);
   import ring_desc_pkg::*;

   localparam int IDX_W = (RING_DEPTH > 1) ? $clog2(RING_DEPTH) : 1;

   typedef logic [DESC_WORDS-1:0][WORD_BITS-1:0] entry_t;

   typedef struct packed {
      logic [1:0][RING_DEPTH-1:0][DESC_WORDS-1:0][WORD_BITS-1:0] mem;
      logic [IDX_W-1:0] rx_idx;
      logic [IDX_W-1:0] tx_idx;
      logic rx_in_pkt;
      logic tx_in_pkt;
      tx_state_t tx_state;
      logic [15:0] mode;
      logic [31:0] prdata;
      logic tx_start;
      logic tx_append;
   } state_t;

   state_t r;
   state_t next_r;

   desc_status_if st ();

   rx_status_pack u_rx_pack (
      .s(st.rx_side)
   );

   tx_status_pack u_tx_pack (
      .s(st.tx_side)
   );

   // Ring words: bit 8 selects ring, 7:4 entry, 3:2 word
   function automatic logic ring_hit(input logic [APB_ADDR_W-1:0] a);
      logic [ENTRY_BITS-1:0] ent;
      ent = a[ENTRY_LSB +: ENTRY_BITS];
      return (a[APB_ADDR_W-1:RING_SEL_BIT+1] == '0) && (a[1:0] == 2'h0)
         && (32'(ent) < RING_DEPTH);
   endfunction

   function automatic logic reg_hit(input logic [APB_ADDR_W-1:0] a);
      return (a == MODE_OFS) || (a == STATE_OFS);
   endfunction

   logic ring_sel;
   logic [IDX_W-1:0] ent_sel;
   logic [1:0] word_sel;
   logic [WORD_BITS-1:0] ring_word;
   logic owned_by_device;
   logic addr_ok;
   logic [15:0] rx_w1;
   logic [15:0] tx_w1;
   logic [IDX_W-1:0] rx_next_idx;
   logic rx_next_owned;
   logic rx_take;
   logic rx_end;
   logic run;
   logic [15:0] state_word;
   logic [RING_DEPTH-1:0] rx_owned;
   logic [RING_DEPTH-1:0] tx_owned;

   // Holder bit of every entry, seen by the chain-miss lookahead and the bus guard
   for (genvar g = 0; g < RING_DEPTH; g++) begin : g_holder
      assign rx_owned[g] = r.mem[0][g][WORD_FLAGS][HOLDER_BIT];
      assign tx_owned[g] = r.mem[1][g][WORD_FLAGS][HOLDER_BIT];
   end

   always_comb begin
      ring_sel = paddr[RING_SEL_BIT];
      ent_sel = paddr[ENTRY_LSB +: IDX_W];
      word_sel = paddr[WORD_LSB +: 2];
      ring_word = r.mem[ring_sel][ent_sel][word_sel];
      owned_by_device = ring_sel ? tx_owned[ent_sel] : rx_owned[ent_sel];
      addr_ok = ring_hit(paddr) || reg_hit(paddr);
      run = r.mode[MODE_RUN_BIT];
      rx_w1 = r.mem[0][r.rx_idx][WORD_FLAGS];
      tx_w1 = r.mem[1][r.tx_idx][WORD_FLAGS];
      rx_next_idx = r.rx_idx + 1'b1;
      rx_next_owned = rx_owned[rx_next_idx];
      // Only a buffer the device owns may be filled
      rx_take = rx_seg_done && run && rx_w1[HOLDER_BIT];
      rx_end = rx_seg_last || rx_overflow || st.rx_miss;
      state_word = '0;
      state_word[STATE_RX_IDX_LSB +: IDX_W] = r.rx_idx;
      state_word[STATE_TX_IDX_LSB +: IDX_W] = r.tx_idx;
      state_word[STATE_RX_PKT_BIT] = r.rx_in_pkt;
      state_word[STATE_TX_PKT_BIT] = r.tx_in_pkt;
      state_word[STATE_TX_FSM_LSB +: 2] = r.tx_state;
   end

   // Inputs to the status packers
   always_comb begin
      st.rx_word = rx_w1;
      st.rx_last = rx_seg_last;
      st.rx_odd = rx_odd_bits;
      st.rx_crc = rx_crc_err;
      st.rx_rx_fifo_overrun = rx_overflow;
      st.rx_miss = !rx_seg_last && !rx_next_owned;
      st.rx_first = !r.rx_in_pkt;
      st.rx_loop = r.mode[MODE_LOOP_BIT];
      st.tx_word = tx_w1;
      st.tx_late = tx_late_collision;
      st.tx_carrier = tx_carrier_lost;
      st.tx_under = tx_underrun;
      st.tx_retry_exh = tx_retry_exhausted;
      st.tx_deferred = tx_deferred;
      st.tx_retries = tx_retry_count;
   end

   // Zero-wait access; refused writes leave storage as it was
   assign pready = psel && penable;
   assign pslverr = psel && penable && (!addr_ok
      || (pwrite && ring_hit(paddr) && owned_by_device));

   always_comb begin
      next_r = r;
      next_r.tx_start = 1'b0;

      // Read data is captured in the setup cycle
      if (psel && !penable && !pwrite) begin
         if (ring_hit(paddr)) begin
            next_r.prdata = {16'h0000, ring_word};
         end else if (paddr == MODE_OFS) begin
            next_r.prdata = {16'h0000, r.mode};
         end else if (paddr == STATE_OFS) begin
            next_r.prdata = {16'h0000, state_word};
         end else begin
            next_r.prdata = 32'h00000000;
         end
      end

      // Host writes reach only entries it currently owns
      if (psel && penable && pwrite) begin
         if (ring_hit(paddr) && !owned_by_device) begin
            next_r.mem[ring_sel][ent_sel][word_sel] = pwdata[15:0];
         end else if (paddr == MODE_OFS) begin
            next_r.mode = pwdata[15:0];
         end
      end

      // Receive write-back; address words are left alone
      if (rx_take) begin
         next_r.mem[0][r.rx_idx][WORD_FLAGS] = st.rx_status;
         if (st.rx_status[LAST_SEG_BIT]) begin
            next_r.mem[0][r.rx_idx][WORD_COUNT] =
               16'(rx_byte_count);
         end
         next_r.rx_idx = rx_next_idx;
         next_r.rx_in_pkt = !rx_end;
      end

      case (r.tx_state)
         TX_OFF: begin
            if (run) begin
               next_r.tx_state = TX_POLL;
            end
         end
         TX_POLL: begin
            if (!run) begin
               next_r.tx_state = TX_OFF;
            end else if (tx_w1[HOLDER_BIT]) begin
               if (tx_w1[FIRST_SEG_BIT] || r.tx_in_pkt) begin
                  next_r.tx_start = 1'b1;
                  next_r.tx_state = TX_SEND;
                  if (tx_w1[FIRST_SEG_BIT]) begin
                     next_r.tx_append = !r.mode[MODE_SUPPRESS_BIT]
                        || tx_w1[APPEND_BIT];
                  end
               end else begin
                  next_r.tx_idx = r.tx_idx + 1'b1;
               end
            end
         end
         TX_SEND: begin
            if (tx_seg_done) begin
               next_r.mem[1][r.tx_idx][WORD_FLAGS] = st.tx_status;
               next_r.tx_idx = r.tx_idx + 1'b1;
               next_r.tx_in_pkt = !tx_w1[LAST_SEG_BIT];
               next_r.tx_state = run ? TX_POLL : TX_OFF;
            end
         end
         default: begin
            next_r.tx_state = TX_OFF;
         end
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         r <= '0;
         r.mode <= MODE_RESET;
         r.tx_state <= TX_OFF;
      end else begin
         r <= next_r;
      end
   end

   assign prdata = r.prdata;
   assign rx_buf_ready = run && rx_w1[HOLDER_BIT];
   assign rx_buf_addr = {rx_w1[ADDR_HIGH_MSB:0],
      r.mem[0][r.rx_idx][WORD_ADDR_LOW]};
   assign tx_start = r.tx_start;
   assign tx_active = (r.tx_state == TX_SEND);
   assign tx_buf_addr = {tx_w1[ADDR_HIGH_MSB:0],
      r.mem[1][r.tx_idx][WORD_ADDR_LOW]};
   assign tx_buf_last = tx_w1[LAST_SEG_BIT];
   assign tx_append_crc = r.tx_append;

endmodule // ring_descriptor_status_logic

/* hw/ring_desc_pkg.sv */
// Constants and types shared by the descriptor status logic
package ring_desc_pkg;
   localparam int DESC_WORDS = 4;
   localparam int WORD_BITS = 16;
   localparam int APB_ADDR_W = 12;
   // Descriptor word numbers within one entry
   localparam logic [1:0] WORD_ADDR_LOW = 2'h0;
   localparam logic [1:0] WORD_FLAGS = 2'h1;
   localparam logic [1:0] WORD_COUNT = 2'h3;
   // Flag word bit positions (shared by receive and transmit entries)
   localparam int HOLDER_BIT = 15;
   localparam int FAULT_BIT = 14;
   localparam int ODD_BITS_BIT = 13;
   localparam int APPEND_BIT = 13;
   localparam int OVERRUN_BIT = 12;
   localparam int MULTI_RETRY_BIT = 12;
   localparam int CRC_ERR_BIT = 11;
   localparam int SINGLE_RETRY_BIT = 11;
   localparam int CHAIN_MISS_BIT = 10;
   localparam int CHANNEL_WAIT_BIT = 10;
   localparam int FIRST_SEG_BIT = 9;
   localparam int LAST_SEG_BIT = 8;
   localparam int ADDR_HIGH_MSB = 7;
   localparam int RX_COUNT_BITS = 12;
   // APB map
   localparam logic [11:0] RX_RING_BASE = 12'h000;
   localparam logic [11:0] TX_RING_BASE = 12'h100;
   localparam logic [11:0] MODE_OFS = 12'h200;
   localparam logic [11:0] STATE_OFS = 12'h204;
   localparam int RING_SEL_BIT = 8;
   localparam int ENTRY_LSB = 4;
   localparam int ENTRY_BITS = 4;
   localparam int WORD_LSB = 2;
   // Mode register fields
   localparam int MODE_RUN_BIT = 0;
   localparam int MODE_LOOP_BIT = 2;
   localparam int MODE_SUPPRESS_BIT = 3;
   localparam logic [15:0] MODE_RESET = 16'h0000;
   // State register fields
   localparam int STATE_RX_IDX_LSB = 0;
   localparam int STATE_TX_IDX_LSB = 4;
   localparam int STATE_RX_PKT_BIT = 8;
   localparam int STATE_TX_PKT_BIT = 9;
   localparam int STATE_TX_FSM_LSB = 10;
   typedef enum logic [1:0] {
      TX_OFF = 2'b00,
      TX_POLL = 2'b01,
      TX_SEND = 2'b10
   } tx_state_t;
endpackage

/* hw/desc_status_if.sv */
// Flag word hand-off between the core and the status packers
`timescale 1ns/10ps
interface desc_status_if;
   logic [15:0] rx_word;
   logic [15:0] rx_status;
   logic rx_last, rx_odd, rx_crc, rx_rx_fifo_overrun, rx_miss, rx_first, rx_loop;
   logic [15:0] tx_word;
   logic [15:0] tx_status;
   logic tx_late, tx_carrier, tx_under, tx_retry_exh, tx_deferred;
   logic [4:0] tx_retries;
   modport core(output rx_word, rx_last, rx_odd, rx_crc, rx_rx_fifo_overrun, rx_miss,
      rx_first, rx_loop, tx_word, tx_late, tx_carrier, tx_under,
      tx_retry_exh, tx_deferred, tx_retries, input rx_status, tx_status);
   modport rx_side(input rx_word, rx_last, rx_odd, rx_crc, rx_rx_fifo_overrun, rx_miss,
      rx_first, rx_loop, output rx_status);
   modport tx_side(input tx_word, tx_late, tx_carrier, tx_under,
      tx_retry_exh, tx_deferred, tx_retries, output tx_status);
endinterface // desc_status_if

/* hw/rx_status_pack.sv */
// Builds the receive flag word written back at the end of a buffer
`timescale 1ns/10ps
module rx_status_pack (
   desc_status_if.rx_side s
);
   import ring_desc_pkg::*;
   logic last_seg, overrun, crc_err, odd_bits;
   always_comb begin
      overrun = s.rx_rx_fifo_overrun;
      last_seg = s.rx_last && !overrun && !s.rx_miss;
      crc_err = s.rx_crc && last_seg;
      odd_bits = s.rx_odd && crc_err && !s.rx_loop;
      s.rx_status = s.rx_word;
      s.rx_status[HOLDER_BIT] = 1'b0;
      s.rx_status[ODD_BITS_BIT] = odd_bits;
      s.rx_status[OVERRUN_BIT] = overrun;
      s.rx_status[CRC_ERR_BIT] = crc_err;
      s.rx_status[CHAIN_MISS_BIT] = s.rx_miss;
      s.rx_status[FIRST_SEG_BIT] = s.rx_first;
      s.rx_status[LAST_SEG_BIT] = last_seg;
      s.rx_status[FAULT_BIT] = odd_bits | overrun | crc_err | s.rx_miss;
   end
endmodule // rx_status_pack

/* hw/tx_status_pack.sv */
// Builds the transmit flag word written back after a buffer is sent
`timescale 1ns/10ps
module tx_status_pack (
   desc_status_if.tx_side s
);
   import ring_desc_pkg::*;
   logic multi, single;
   always_comb begin
      multi = s.tx_retries > 5'h01;
      single = (s.tx_retries == 5'h01) && !s.tx_late;
      // Host-set bits 13, 9, 8 and the high address pass through
      s.tx_status = s.tx_word;
      s.tx_status[HOLDER_BIT] = 1'b0;
      s.tx_status[MULTI_RETRY_BIT] = multi;
      s.tx_status[SINGLE_RETRY_BIT] = single;
      s.tx_status[CHANNEL_WAIT_BIT] = s.tx_deferred;
      s.tx_status[FAULT_BIT] = s.tx_late | s.tx_carrier | s.tx_under
         | s.tx_retry_exh;
   end
endmodule // tx_status_pack

/* tb/ring_desc_monitor.sv */
// Port-level checks for the descriptor status block
`timescale 1ns/10ps
module ring_desc_monitor #(
   parameter int RING_DEPTH = 4
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic rx_seg_done,
   input wire logic rx_buf_ready,
   input wire logic [23:0] rx_buf_addr,
   input wire logic tx_seg_done,
   input wire logic tx_start,
   input wire logic tx_active,
   input wire logic [23:0] tx_buf_addr,
   input wire logic tx_append_crc
);
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);
   sequence s_send_end;
      tx_active && tx_seg_done;
   endsequence
   sequence s_send_mid;
      tx_active && !tx_start;
   endsequence
   property p_rx_refuse;
      rx_seg_done && !rx_buf_ready && !(psel && penable)
         |=> !rx_buf_ready && $stable(rx_buf_addr);
   endproperty
   AST_ZERO_WAIT: assert property (psel && penable |-> pready)
      else $error("pready missing in access cycle");
   AST_ERR_IN_ACCESS: assert property (pslverr |-> psel && penable)
      else $error("pslverr outside access cycle");
   AST_START_PULSE: assert property (tx_start |-> tx_active ##1 !tx_start)
      else $error("tx_start not a single pulse within send");
   AST_SEND_HOLD: assert property (tx_active && !tx_seg_done |=> tx_active)
      else $error("send ended without done");
   AST_SEND_RELEASE: assert property (s_send_end |=> !tx_active && !tx_start)
      else $error("no poll cycle after write-back");
   AST_ADDR_STEADY: assert property (s_send_mid |-> $stable(tx_buf_addr))
      else $error("tx buffer address moved during send");
   AST_APPEND_STEADY: assert property (s_send_mid |-> $stable(tx_append_crc))
      else $error("crc append decision moved during send");
   AST_RX_REFUSE: assert property (p_rx_refuse)
      else $error("unowned rx segment was accepted");
   cover property (s_send_end);
endmodule // ring_desc_monitor

bind ring_descriptor_status_logic ring_desc_monitor
   #(.RING_DEPTH(RING_DEPTH)) mon (
   .pclk, .presetn, .psel, .penable, .pready, .pslverr, .rx_seg_done,
   .rx_buf_ready, .rx_buf_addr, .tx_seg_done, .tx_start, .tx_active,
   .tx_buf_addr, .tx_append_crc
);

/* tb/mac_partner.sv */
// MAC stand-in: ends each send after a chosen lag with chosen status
`timescale 1ns/10ps
module mac_partner (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic tx_start,
   input wire logic tx_active,
   input wire logic [3:0] lag,
   input wire logic [9:0] stat,
   output logic tx_seg_done,
   output logic [9:0] status
);
   logic [3:0] cnt;
   // Status lines carry meaning only beside the done pulse
   assign status = tx_seg_done ? stat : ~stat;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt <= 4'h0;
         tx_seg_done <= 1'b0;
      end else begin
         tx_seg_done <= 1'b0;
         if (tx_start) begin
            cnt <= lag;
         end else if (tx_active && !tx_seg_done && cnt != 4'h0) begin
            cnt <= cnt - 4'h1;
            tx_seg_done <= (cnt == 4'h1);
         end
      end
   end
endmodule // mac_partner

/* tb/ring_descriptor_status_logic_test.sv */
// Self-checking bench: APB host accesses and MAC-side stimulus
`timescale 1ns/10ps
module ring_descriptor_status_logic_test;
   import ring_desc_pkg::*;
   logic pclk = 0;
   logic presetn = 0;
   logic psel = 0;
   logic penable = 0;
   logic pwrite = 0;
   logic [11:0] paddr = 12'h0;
   logic [31:0] pwdata = 32'h0;
   logic rx_seg_done = 0;
   logic rx_seg_last = 0;
   logic rx_odd_bits = 0;
   logic rx_crc_err = 0;
   logic rx_overflow = 0;
   logic [11:0] rx_byte_count = 12'h0;
   logic [3:0] lag = 4'h2;
   logic [9:0] stat = 10'h0;
   logic [31:0] prdata, rdat;
   logic pready, pslverr, rx_buf_ready, tx_start, tx_active, err;
   logic tx_buf_last, tx_append_crc, tx_seg_done, tx_deferred;
   logic tx_late_collision, tx_carrier_lost, tx_underrun, tx_retry_exhausted;
   logic [23:0] rx_buf_addr, tx_buf_addr;
   logic [4:0] tx_retry_count;
   logic [9:0] status;
   int num_errors = 0;
   int checked = 0;
   int cycles = 0;
   assign {tx_late_collision, tx_carrier_lost, tx_underrun} = status[9:7];
   assign {tx_retry_exhausted, tx_deferred, tx_retry_count} = status[6:0];
   always #2.5 pclk = ~pclk;
   ring_descriptor_status_logic #(.RING_DEPTH(4)) dut (
      .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
      .pready, .pslverr, .rx_seg_done, .rx_seg_last, .rx_odd_bits,
      .rx_crc_err, .rx_overflow, .rx_byte_count, .rx_buf_ready,
      .rx_buf_addr, .tx_seg_done, .tx_late_collision, .tx_carrier_lost,
      .tx_underrun, .tx_retry_exhausted, .tx_deferred, .tx_retry_count,
      .tx_start, .tx_active, .tx_buf_addr, .tx_buf_last, .tx_append_crc
   );
   mac_partner mac (
      .pclk, .presetn, .tx_start, .tx_active, .lag, .stat, .tx_seg_done,
      .status
   );
   task automatic tally_and_finish();
      $display("checked %0d num_errors %0d", checked, num_errors);
      if (num_errors == 0 && checked > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   always @(posedge pclk) begin
      cycles <= cycles + 1;
      if (cycles == 4000) begin
         num_errors++;
         tally_and_finish();
      end
   end
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         num_errors++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   function automatic logic [11:0] ad(input int tx, input int e, input int w);
      return (tx != 0 ? TX_RING_BASE : RX_RING_BASE) + 12'(16 * e + 4 * w);
   endfunction
   // Expected receive flag word for a segment and the ring state it met
   function automatic logic [15:0] rxw(input logic f, l, o, c, v, m, lp,
      input logic [7:0] hi);
      logic lr, cr, od;
      lr = l && !v && !m;
      cr = c && lr;
      od = o && cr && !lp;
      return {1'b0, od | v | cr | m, od, v, cr, m, f, lr, hi};
   endfunction
   function automatic logic [15:0] txw(input logic [15:0] h,
      input logic [9:0] s);
      return {1'b0, |s[9:6], h[13], s[4:0] > 5'h1,
         s[4:0] == 5'h1 && !s[9], s[5], h[9:0]};
   endfunction
   task automatic xfer(input logic w, input logic [11:0] a,
      input logic [31:0] d);
      int n;
      n = 0;
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1 && n < 20) begin
         @(posedge pclk);
         n++;
      end
      if (pready !== 1'b1) num_errors++;
      rdat = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask
   task automatic rdchk(input logic [11:0] a, input logic [15:0] exp);
      xfer(1'b0, a, 32'h0);
      chk(rdat, {16'h0, exp});
   endtask
   task automatic rxseg(input logic l, o, c, v, input logic [11:0] n);
      rx_seg_done <= 1'b1;
      rx_seg_last <= l;
      rx_odd_bits <= o;
      rx_crc_err <= c;
      rx_overflow <= v;
      rx_byte_count <= n;
      @(posedge pclk);
      rx_seg_done <= 1'b0;
      @(posedge pclk);
   endtask
   task automatic txpkt(input int e, input logic [15:0] h, lo,
      input logic app, input logic [9:0] s);
      int n;
      n = 0;
      stat <= s;
      while (tx_start !== 1'b1 && n < 100) begin
         @(posedge pclk);
         n++;
      end
      chk(32'(tx_buf_addr), {8'h0, h[7:0], lo});
      chk(32'(tx_buf_last), 32'(h[8]));
      @(posedge pclk);
      chk(32'(tx_append_crc), 32'(app));
      while (tx_active !== 1'b0 && n < 200) begin
         @(posedge pclk);
         n++;
      end
      rdchk(ad(1, e, 1), txw(h, s));
   endtask
   initial begin
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      rdchk(ad(0, 0, 1), 16'h0);
      xfer(1'b0, 12'h300, 32'h0);
      chk(32'(err), 32'h1);
      for (int e = 0; e < 4; e++) begin
         xfer(1'b1, ad(0, e, 0), 32'hA000 + 32'(e));
         xfer(1'b1, ad(0, e, 1), 32'h8010 + 32'(e));
      end
      xfer(1'b1, ad(0, 0, 0), 32'h1234);
      chk(32'(err), 32'h1);
      xfer(1'b1, MODE_OFS, 32'h1);
      chk({7'h0, rx_buf_ready, rx_buf_addr}, 32'h0110A000);
      rxseg(1, 1, 1, 0, 12'h040);
      rdchk(ad(0, 0, 1), rxw(1, 1, 1, 1, 0, 0, 0, 8'h10));
      rxseg(0, 0, 0, 0, 12'h0);
      rdchk(ad(0, 1, 1), rxw(1, 0, 0, 0, 0, 0, 0, 8'h11));
      rxseg(1, 1, 0, 0, 12'h05C);
      rdchk(ad(0, 2, 1), rxw(0, 1, 1, 0, 0, 0, 0, 8'h12));
      rdchk(ad(0, 2, 3), 16'h005C);
      rxseg(0, 0, 0, 1, 12'h0);
      rdchk(ad(0, 3, 1), rxw(1, 0, 0, 0, 1, 1, 0, 8'h13));
      rdchk(ad(0, 0, 0), 16'hA000);
      xfer(1'b1, MODE_OFS, 32'h5);
      xfer(1'b1, ad(0, 0, 1), 32'h8010);
      rxseg(1, 1, 1, 0, 12'h040);
      rdchk(ad(0, 0, 1), rxw(1, 1, 1, 1, 0, 0, 1, 8'h10));
      chk(32'(rx_buf_ready), 32'h0);
      rxseg(1, 0, 0, 0, 12'h040);
      rdchk(ad(0, 1, 1), rxw(1, 0, 0, 0, 0, 0, 0, 8'h11));
      xfer(1'b1, ad(0, 1, 1), 32'h8011);
      rxseg(0, 0, 0, 0, 12'h0);
      rdchk(ad(0, 1, 1), rxw(1, 0, 0, 0, 0, 1, 0, 8'h11));
      xfer(1'b1, MODE_OFS, 32'h8);
      xfer(1'b1, ad(1, 0, 1), 32'h8020);
      xfer(1'b1, ad(1, 1, 0), 32'hB001);
      xfer(1'b1, ad(1, 1, 1), 32'h8321);
      xfer(1'b1, MODE_OFS, 32'h9);
      txpkt(1, 16'h8321, 16'hB001, 1'b0, 10'h021);
      rdchk(ad(1, 0, 1), 16'h8020);
      lag <= 4'h6;
      xfer(1'b1, ad(1, 2, 1), 32'hA322);
      txpkt(2, 16'hA322, 16'h0, 1'b1, 10'h201);
      xfer(1'b1, MODE_OFS, 32'h1);
      xfer(1'b1, ad(1, 3, 1), 32'h8323);
      txpkt(3, 16'h8323, 16'h0, 1'b1, 10'h1C5);
      xfer(1'b1, MODE_OFS, 32'h9);
      xfer(1'b1, ad(1, 1, 1), 32'h8221);
      txpkt(1, 16'h8221, 16'hB001, 1'b0, 10'h082);
      rdchk(STATE_OFS, 16'h0622);
      xfer(1'b1, ad(1, 2, 1), 32'hA122);
      txpkt(2, 16'hA122, 16'h0, 1'b0, 10'h000);
      presetn <= 1'b0;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      rdchk(ad(1, 3, 1), 16'h0);
      tally_and_finish();
   end
endmodule // ring_descriptor_status_logic_test
